// ===== rtl/pdm_pkg.sv
// Constants and types for the power-down mode controller
//
// Functional notes
// - Standby enable bit 7, settle select bits 6..4, control register resets to 09.
// - Sleep instruction enters sleep if standby enable is 0, else software standby.
// - Interrupt exit from software standby leaves standby enable set; only software clears.
// - Non-flash settle codes: 8192, 16384, 32768, 65536, 131072 states; 11x unused.
// - Flash variant: code 100 gives 131072, code 101 gives 1024 states.
// - While settling, oscillator runs, CPU and peripherals stay in standby.
// - Sleep halts the CPU, keeps its registers, peripherals keep running.
// - Any enabled interrupt in sleep releases sleep and starts interrupt handling.
// - Disabled interrupts never wake; with CPU mask set only the non-maskable wakes.
// - Reset pin low during sleep moves the device to the reset state.
// - Standby pin low in sleep or software standby enters hardware standby.
// - Software standby stops the clock, halts and initialises peripherals, keeps CPU.
// - Software standby exits only by reset, standby pin, NMI, EXT_INTERRUPT_0..2 or EXT_INTERRUPT_6.
// - Wake interrupt starts oscillator, waits settle time, then clock, release, handling.
// - Reset low in standby starts oscillator; its rise starts reset handling.
// - Hardware standby exit: standby pin rises first, reset rises after settling.

package pdm_pkg;

	localparam logic [15:0] SYSCTL_ADDR = 16'hFFC4;
	localparam logic [7:0] SYSCTL_RESET = 8'h09;
	localparam logic [7:0] SYSCTL_WMASK = 8'hF7;
	localparam int STANDBY_ENABLE_BIT = 7;
	localparam int STS_LSB = 4;
	localparam int STS_W = 3;
	localparam int EXTERNAL_RESET_FLAG_BIT = 3;
	localparam int NMI_EDGE_SELECT_BIT = 2;
	localparam int HIE_BIT = 1;
	localparam int ONCHIP_RAM_ENABLE_BIT = 0;

	// Settle lengths in units of 1024 states
	localparam int SETTLE_UNIT_STATES = 1024;
	localparam int MUL_CODE0 = 8;
	localparam int MUL_CODE1 = 16;
	localparam int MUL_CODE2 = 32;
	localparam int MUL_CODE3 = 64;
	localparam int MUL_CODE4 = 128;
	localparam int MUL_FLASH5 = 1;

	// One state is one system clock cycle at 100 MHz
	localparam int CLK_PERIOD_NS = 10;
	localparam int STATE_NS = 10;
	localparam int CYCLES_PER_STATE = STATE_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		PDM_RUN,
		PDM_SLEEP,
		PDM_SWSTBY,
		PDM_SETTLE,
		PDM_HWSTBY,
		PDM_RSTHOLD
	} pdm_state_t;

endpackage

// ===== rtl/pdm_settle_if.sv
// Link between the mode sequencer and its settle counter
`timescale 1ns/100ps

interface pdm_settle_if #(
	parameter int CW = 18
);
	logic load;
	logic abort;
	logic [CW-1:0] count;
	logic done;

	modport ctrl (
		output load,
		output abort,
		output count,
		input done
	);

	modport cnt (
		input load,
		input abort,
		input count,
		output done
	);
endinterface

// ===== rtl/pdm_settle_counter.sv
// Oscillator settling counter, one count per state
`timescale 1ns/100ps

module pdm_settle_counter #(
	parameter int CW = 18
) (
	input wire logic clk_sys,
	input wire logic reset,
	pdm_settle_if.cnt sif
);

	logic [CW-1:0] remain;
	logic running;

	// Done leads by one cycle so settle ends exactly count cycles after load; minimum is 2
	always_ff @(posedge clk_sys) begin
		if (reset || sif.abort) begin
			remain <= '0;
			running <= 1'b0;
			sif.done <= 1'b0;
		end else if (sif.load) begin
			remain <= sif.count;
			running <= 1'b1;
			sif.done <= 1'b0;
		end else if (running) begin
			remain <= remain - 1'b1;
			sif.done <= (remain <= CW'(2));
			running <= (remain > CW'(2));
		end else begin
			sif.done <= 1'b0;
		end
	end

	counter_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
		sif.load && sif.count > 2 && !sif.abort |=> !sif.done [*2])
		else $error("settle done came too early");

endmodule

// ===== rtl/pdm_power_down.sv
// Power-down mode controller with its system control register
`timescale 1ns/100ps

module pdm_power_down #(
	parameter bit FLASH_VARIANT = 1'b0,
	parameter int SETTLE_UNIT = pdm_pkg::SETTLE_UNIT_STATES
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic sleepExec,
	input wire logic cpuMaskI,
	input wire logic intReq,
	input wire logic nmiReq,
	input wire logic [2:0] extInterruptLow,
	input wire logic extInterrupt6,
	input wire logic resetPinN,
	input wire logic standbyPinN,
	output logic cpuHalt,
	output logic periphRun,
	output logic periphInit,
	output logic sysClockRun,
	output logic oscRun,
	output logic hwStandby,
	output logic intStart,
	output logic resetStart,
	output logic standbyEnable,
	output logic nmiEdgeSelect,
	output logic hostIfEnable,
	output logic onchipRamEnable
);

	localparam int CW = $clog2(SETTLE_UNIT * pdm_pkg::MUL_CODE4 + 1);

	pdm_pkg::pdm_state_t state;
	pdm_pkg::pdm_state_t next_state;
	logic [7:0] systemControl;
	logic maskAtSleep;
	logic regHit;
	logic regWrite;
	logic sleepWake;
	logic standbyWake;
	logic [CW-1:0] settleTarget;

	pdm_settle_if #(.CW(CW)) sif ();

	pdm_settle_counter #(.CW(CW)) u_settle (
		.clk_sys(clk_sys),
		.reset(reset),
		.sif(sif)
	);

	////////////////////////////////////////////////////////////////////////////
	// Settle length decode

	function automatic logic [CW-1:0] settleCount(input logic [2:0] code);
		int mul;
		mul = pdm_pkg::MUL_CODE4;
		case (code)
			3'h0: mul = pdm_pkg::MUL_CODE0;
			3'h1: mul = pdm_pkg::MUL_CODE1;
			3'h2: mul = pdm_pkg::MUL_CODE2;
			3'h3: mul = pdm_pkg::MUL_CODE3;
			3'h4: mul = pdm_pkg::MUL_CODE4;
			// Flash parts shorten code 101; others treat 10x alike
			3'h5: mul = FLASH_VARIANT ? pdm_pkg::MUL_FLASH5 : pdm_pkg::MUL_CODE4;
			// Unused codes take the longest wait, the safe side
			default: mul = pdm_pkg::MUL_CODE4;
		endcase
		return CW'(SETTLE_UNIT * mul * pdm_pkg::CYCLES_PER_STATE);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Wishbone slave

	assign regHit = wb_adr_i[15:2] == pdm_pkg::SYSCTL_ADDR[15:2];
	assign regWrite = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && regHit && wb_sel_i[0];

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	// Unmapped reads return zero; bits above the byte read zero
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
			wb_dat_o <= regHit ? {24'h00_0000, systemControl} : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// System control register

	// Pin reset reinitialises it; standby enable survives interrupt wake
	always_ff @(posedge clk_sys) begin
		if (reset || state == pdm_pkg::PDM_RSTHOLD || state == pdm_pkg::PDM_HWSTBY) begin
			systemControl <= pdm_pkg::SYSCTL_RESET;
		end else if (regWrite) begin
			systemControl <= (systemControl & ~pdm_pkg::SYSCTL_WMASK)
				| (wb_dat_i[7:0] & pdm_pkg::SYSCTL_WMASK);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Wake sources

	// Interrupt mask is sampled as sleep executes
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			maskAtSleep <= 1'b0;
		end else if (state == pdm_pkg::PDM_RUN && sleepExec) begin
			maskAtSleep <= cpuMaskI;
		end
	end

	// intReq carries only requests enabled in their own modules
	assign sleepWake = nmiReq || (intReq && !maskAtSleep);
	// Other external lines cannot wake software standby
	assign standbyWake = nmiReq || (|extInterruptLow) || extInterrupt6;

	////////////////////////////////////////////////////////////////////////////
	// Mode sequencer

	always_comb begin
		next_state = state;
		case (state)
			pdm_pkg::PDM_RUN: begin
				if (!standbyPinN) begin
					next_state = pdm_pkg::PDM_HWSTBY;
				end else if (!resetPinN) begin
					next_state = pdm_pkg::PDM_RSTHOLD;
				end else if (sleepExec) begin
					next_state = systemControl[pdm_pkg::STANDBY_ENABLE_BIT]
						? pdm_pkg::PDM_SWSTBY : pdm_pkg::PDM_SLEEP;
				end
			end
			pdm_pkg::PDM_SLEEP: begin
				if (!standbyPinN) begin
					next_state = pdm_pkg::PDM_HWSTBY;
				end else if (!resetPinN) begin
					next_state = pdm_pkg::PDM_RSTHOLD;
				end else if (sleepWake) begin
					next_state = pdm_pkg::PDM_RUN;
				end
			end
			pdm_pkg::PDM_SWSTBY: begin
				if (!standbyPinN) begin
					next_state = pdm_pkg::PDM_HWSTBY;
				end else if (!resetPinN) begin
					next_state = pdm_pkg::PDM_RSTHOLD;
				end else if (standbyWake) begin
					next_state = pdm_pkg::PDM_SETTLE;
				end
			end
			pdm_pkg::PDM_SETTLE: begin
				if (!standbyPinN) begin
					next_state = pdm_pkg::PDM_HWSTBY;
				end else if (!resetPinN) begin
					next_state = pdm_pkg::PDM_RSTHOLD;
				end else if (sif.done) begin
					next_state = pdm_pkg::PDM_RUN;
				end
			end
			pdm_pkg::PDM_HWSTBY: begin
				// Oscillator restarts here; reset is expected still low
				if (standbyPinN) begin
					next_state = pdm_pkg::PDM_RSTHOLD;
				end
			end
			pdm_pkg::PDM_RSTHOLD: begin
				if (!standbyPinN) begin
					next_state = pdm_pkg::PDM_HWSTBY;
				end else if (resetPinN) begin
					next_state = pdm_pkg::PDM_RUN;
				end
			end
			default: begin
				next_state = pdm_pkg::PDM_RSTHOLD;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state <= pdm_pkg::PDM_RUN;
		end else begin
			state <= next_state;
		end
	end

	// Counter loads on the wake edge and is dropped on any other exit
	assign sif.load = state == pdm_pkg::PDM_SWSTBY && next_state == pdm_pkg::PDM_SETTLE;
	assign sif.abort = state == pdm_pkg::PDM_SETTLE && next_state != pdm_pkg::PDM_SETTLE;
	assign sif.count = settleCount(systemControl[pdm_pkg::STS_LSB +: pdm_pkg::STS_W]);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			settleTarget <= '0;
		end else if (sif.load) begin
			settleTarget <= sif.count;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered controls toward the core

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cpuHalt <= 1'b0;
			periphRun <= 1'b1;
			periphInit <= 1'b0;
			sysClockRun <= 1'b1;
			oscRun <= 1'b1;
			hwStandby <= 1'b0;
		end else begin
			cpuHalt <= next_state != pdm_pkg::PDM_RUN;
			periphRun <= next_state == pdm_pkg::PDM_RUN
				|| next_state == pdm_pkg::PDM_SLEEP;
			periphInit <= next_state inside {pdm_pkg::PDM_SWSTBY, pdm_pkg::PDM_SETTLE,
				pdm_pkg::PDM_HWSTBY, pdm_pkg::PDM_RSTHOLD};
			sysClockRun <= next_state == pdm_pkg::PDM_RUN
				|| next_state == pdm_pkg::PDM_SLEEP;
			oscRun <= next_state != pdm_pkg::PDM_SWSTBY
				&& next_state != pdm_pkg::PDM_HWSTBY;
			hwStandby <= next_state == pdm_pkg::PDM_HWSTBY;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			intStart <= 1'b0;
			resetStart <= 1'b0;
		end else begin
			intStart <= next_state == pdm_pkg::PDM_RUN
				&& (state == pdm_pkg::PDM_SLEEP || state == pdm_pkg::PDM_SETTLE);
			resetStart <= next_state == pdm_pkg::PDM_RUN
				&& state == pdm_pkg::PDM_RSTHOLD;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			standbyEnable <= 1'b0;
			nmiEdgeSelect <= 1'b0;
			hostIfEnable <= 1'b0;
			onchipRamEnable <= 1'b1;
		end else begin
			standbyEnable <= systemControl[pdm_pkg::STANDBY_ENABLE_BIT];
			nmiEdgeSelect <= systemControl[pdm_pkg::NMI_EDGE_SELECT_BIT];
			hostIfEnable <= systemControl[pdm_pkg::HIE_BIT];
			onchipRamEnable <= systemControl[pdm_pkg::ONCHIP_RAM_ENABLE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	logic [CW:0] settleSeen;

	always_ff @(posedge clk_sys) begin
		if (reset || state != pdm_pkg::PDM_SETTLE) begin
			settleSeen <= '0;
		end else begin
			settleSeen <= settleSeen + 1'b1;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	reg_after_reset_a: assert property ($fell(reset) |->
		systemControl == pdm_pkg::SYSCTL_RESET && !wb_ack_o)
		else $error("control register not at reset value");

	sleep_select_a: assert property (
		state == pdm_pkg::PDM_RUN && sleepExec && resetPinN && standbyPinN |=>
		state == ($past(systemControl[pdm_pkg::STANDBY_ENABLE_BIT])
			? pdm_pkg::PDM_SWSTBY : pdm_pkg::PDM_SLEEP))
		else $error("wrong low-power mode chosen");

	standby_enable_kept_a: assert property (
		state == pdm_pkg::PDM_SETTLE && !regWrite |=> systemControl[pdm_pkg::STANDBY_ENABLE_BIT])
		else $error("standby enable lost on wake");

	settle_length_a: assert property (
		state == pdm_pkg::PDM_SETTLE ##1 state == pdm_pkg::PDM_RUN |->
		settleSeen == {1'b0, settleTarget} && intStart && sysClockRun)
		else $error("settle time not as selected");

	settle_outputs_a: assert property (
		state == pdm_pkg::PDM_SETTLE |-> oscRun && cpuHalt && !periphRun && periphInit)
		else $error("settle controls wrong");

	sleep_outputs_a: assert property (
		state == pdm_pkg::PDM_SLEEP |-> cpuHalt && periphRun && sysClockRun)
		else $error("sleep controls wrong");

	sleep_wake_a: assert property (
		state == pdm_pkg::PDM_SLEEP && nmiReq && resetPinN && standbyPinN |=>
		state == pdm_pkg::PDM_RUN && intStart ##1 !intStart)
		else $error("interrupt did not release sleep");

	mask_block_a: assert property (
		state == pdm_pkg::PDM_SLEEP && maskAtSleep && !nmiReq && resetPinN && standbyPinN
		|=> state == pdm_pkg::PDM_SLEEP)
		else $error("masked interrupt woke the core");

	sleep_reset_a: assert property (
		state == pdm_pkg::PDM_SLEEP && !resetPinN && standbyPinN |=>
		state == pdm_pkg::PDM_RSTHOLD)
		else $error("reset pin did not leave sleep");

	hw_entry_a: assert property (
		(state == pdm_pkg::PDM_SLEEP || state == pdm_pkg::PDM_SWSTBY) && !standbyPinN
		|=> state == pdm_pkg::PDM_HWSTBY && hwStandby)
		else $error("standby pin ignored");

	swstby_outputs_a: assert property (
		state == pdm_pkg::PDM_SWSTBY |-> !sysClockRun && !oscRun && cpuHalt && periphInit)
		else $error("software standby controls wrong");

	swstby_hold_a: assert property (
		state == pdm_pkg::PDM_SWSTBY && !standbyWake && resetPinN && standbyPinN
		|=> state == pdm_pkg::PDM_SWSTBY)
		else $error("software standby left without cause");

	reset_rise_a: assert property (
		state == pdm_pkg::PDM_RSTHOLD && resetPinN && standbyPinN |=>
		resetStart && state == pdm_pkg::PDM_RUN)
		else $error("reset rise did not start handling");

	hw_recover_a: assert property (
		state == pdm_pkg::PDM_HWSTBY && standbyPinN |=>
		state == pdm_pkg::PDM_RSTHOLD && oscRun)
		else $error("hardware standby recovery wrong");

	sleep_wake_c: cover property (state == pdm_pkg::PDM_SLEEP ##1 intStart);
	standby_wake_c: cover property (state == pdm_pkg::PDM_SETTLE ##1 intStart);
	hw_cycle_c: cover property (hwStandby ##[1:20] resetStart);
	bus_write_c: cover property (regWrite ##1 !wb_ack_o);

endmodule

// ===== tb/pdm_pin_model.sv
// Model of the external reset, standby and interrupt pins
`timescale 1ns/100ps

module pdm_pin_model (
	input wire logic clk_sys,
	output logic resetPinN,
	output logic standbyPinN,
	output logic nmiReq,
	output logic [2:0] extInterruptLow,
	output logic extInterrupt6,
	output logic intReq
);
	initial begin
		resetPinN = 1'b1;
		standbyPinN = 1'b1;
		nmiReq = 1'b0;
		extInterruptLow = 3'h0;
		extInterrupt6 = 1'b0;
		intReq = 1'b0;
	end

	// Source 0 is the non-maskable one, 1..3 the low external ones, 4 the key group, 5 general
	task src(input int s, input logic lvl);
		@(posedge clk_sys);
		if (s == 0) nmiReq <= lvl;
		// Lines 3, 4, 5 and 7 get no source, as if disabled before standby
		else if (s < 4) extInterruptLow[s-1] <= lvl;
		else if (s == 4) extInterrupt6 <= lvl;
		else intReq <= lvl;
	endtask

	// Caller holds reset low long enough for the oscillator to settle
	task rst(input logic lvl);
		@(posedge clk_sys);
		resetPinN <= lvl;
	endtask

	// Standby rises only while reset is still held low
	task standby_pin(input logic lvl);
		@(posedge clk_sys);
		if (lvl && resetPinN) resetPinN <= 1'b0;
		standbyPinN <= lvl;
	endtask
endmodule

// ===== tb/pdm_power_down_tb.sv
// Self-checking bench for the power-down mode controller
`timescale 1ns/100ps

module pdm_power_down_tb;
	localparam int SU = 2;
	localparam logic [15:0] ADR = pdm_pkg::SYSCTL_ADDR;
	logic clk_sys, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sleepExec, cpuMaskI;
	logic [15:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [3:0] wbSel;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic resetPinN, standbyPinN, nmiReq, extInterrupt6, intReq, intStartF;
	logic [2:0] extInterruptLow;
	logic cpuHalt, periphRun, periphInit, sysClockRun, oscRun, hwStandby, intStart;
	logic resetStart, standbyEnable, nmiEdgeSelect, hostIfEnable, onchipRamEnable;
	int err_count, n_compared;

	pdm_power_down #(.SETTLE_UNIT(SU)) pdm_power_down_i (.*);
	// Flash build shares every input; only its settle pulse is watched
	pdm_power_down #(.FLASH_VARIANT(1'b1), .SETTLE_UNIT(SU)) pdm_power_down_flash_i (.*,
		.wb_dat_o(), .wb_ack_o(), .cpuHalt(), .periphRun(), .periphInit(), .sysClockRun(),
		.oscRun(), .hwStandby(), .intStart(intStartF), .resetStart(), .standbyEnable(),
		.nmiEdgeSelect(), .hostIfEnable(), .onchipRamEnable());
	pdm_pin_model pdm_pin_model_i (.*);

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task check1(input string what, input logic seen, input logic exp);
		check(what, {31'h0, seen}, {31'h0, exp});
	endtask

	task summarize;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task wb(input logic we, input logic [15:0] adr, input logic [7:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= wbSel;
		wb_adr_i <= adr;
		wb_dat_i <= {24'h000000, d};
		@(posedge clk_sys);
		while (wb_ack_o !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk_sys);
		end
		check1("bus ack", wb_ack_o, 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task step;
		@(posedge clk_sys);
		#1;
	endtask

	task do_sleep(input logic mask);
		@(posedge clk_sys);
		sleepExec <= 1'b1;
		cpuMaskI <= mask;
		@(posedge clk_sys);
		sleepExec <= 1'b0;
		#1;
	endtask

	task wake(input int s);
		pdm_pin_model_i.src(s, 1'b1);
		step();
		check1("interrupt start", intStart, 1'b1);
		check1("cpu resumed", cpuHalt, 1'b0);
		step();
		check1("start pulse ends", intStart, 1'b0);
		pdm_pin_model_i.src(s, 1'b0);
	endtask

	function automatic int settle(input int code, input bit flash);
		if (code == 5 && flash) return pdm_pkg::MUL_FLASH5 * SU;
		if (code == 0) return pdm_pkg::MUL_CODE0 * SU;
		if (code == 1) return pdm_pkg::MUL_CODE1 * SU;
		if (code == 2) return pdm_pkg::MUL_CODE2 * SU;
		if (code == 3) return pdm_pkg::MUL_CODE3 * SU;
		return pdm_pkg::MUL_CODE4 * SU;
	endfunction

	////////////////////////////////////////
	task t_regs;
		logic [31:0] q;
		wb(1'b0, ADR, 8'h00, q);
		check("reset value", q, 32'h09);
		wb(1'b1, ADR, 8'hF6, q);
		wb(1'b0, ADR, 8'h00, q);
		check("written value", q, 32'hFE);
		check1("standby enable", standbyEnable, 1'b1);
		check1("ram enable", onchipRamEnable, 1'b0);
		check1("nmi edge select", nmiEdgeSelect, 1'b1);
		check1("host if enable", hostIfEnable, 1'b1);
		wb(1'b1, ADR + 16'h0004, 8'hFF, q);
		wb(1'b0, ADR + 16'h0004, 8'h00, q);
		check("unmapped read", q, 32'h0);
		wb(1'b1, ADR, 8'h01, q);
		wb(1'b0, ADR, 8'h00, q);
		check("cleared value", q, 32'h09);
		// Byte lane 0 off: the write must not land
		wbSel = 4'hE;
		wb(1'b1, ADR, 8'h80, q);
		wbSel = 4'hF;
		wb(1'b0, ADR, 8'h00, q);
		check("lane 0 off", q, 32'h09);
	endtask

	// Reset in mid-run puts every control bit back
	task t_reset;
		logic [31:0] q;
		wb(1'b1, ADR, 8'hF6, q);
		reset <= 1'b1;
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		wb(1'b0, ADR, 8'h00, q);
		check("value after reset", q, 32'h09);
		check1("enable after reset", standbyEnable, 1'b0);
	endtask

	task t_sleep(input logic mask);
		do_sleep(mask);
		check1("cpu halted", cpuHalt, 1'b1);
		check1("periph running", periphRun, 1'b1);
		check1("clock running", sysClockRun, 1'b1);
		if (mask) begin
			pdm_pin_model_i.src(5, 1'b1);
			repeat (3) step();
			check1("masked request", cpuHalt, 1'b1);
			pdm_pin_model_i.src(5, 1'b0);
		end
		wake(mask ? 0 : 5);
	endtask

	// Reset pin from sleep or software standby
	task t_rst(input logic standby_enable);
		logic [31:0] q;
		wb(1'b1, ADR, {standby_enable, 7'h01}, q);
		do_sleep(1'b0);
		pdm_pin_model_i.rst(1'b0);
		step();
		check1("osc on in reset", oscRun, 1'b1);
		check1("halt in reset", cpuHalt, 1'b1);
		repeat (5) step();
		pdm_pin_model_i.rst(1'b1);
		step();
		check1("reset start", resetStart, 1'b1);
		step();
		check1("reset pulse ends", resetStart, 1'b0);
		wb(1'b0, ADR, 8'h00, q);
		check("reloaded", q, 32'h09);
	endtask

	task t_swstby(input int code);
		logic [31:0] q;
		int n, e, f;
		wb(1'b1, ADR, {1'b1, code[2:0], 4'h1}, q);
		do_sleep(1'b0);
		check1("clock stopped", sysClockRun, 1'b0);
		check1("periph init", periphInit, 1'b1);
		pdm_pin_model_i.src(5, 1'b1);
		repeat (3) step();
		check1("general request refused", oscRun, 1'b0);
		pdm_pin_model_i.src(5, 1'b0);
		pdm_pin_model_i.src(code % 5, 1'b1);
		step();
		check1("osc settling", oscRun, 1'b1);
		check1("cpu held", cpuHalt, 1'b1);
		check1("periph held", periphInit, 1'b1);
		n = 0;
		e = 0;
		f = 0;
		while ((e == 0 || f == 0) && n < 300) begin
			step();
			n++;
			if (intStart === 1'b1) e = n;
			if (intStartF === 1'b1) f = n;
		end
		check("settle cycles", e, settle(code, 1'b0));
		check("flash settle cycles", f, settle(code, 1'b1));
		pdm_pin_model_i.src(code % 5, 1'b0);
		wb(1'b0, ADR, 8'h00, q);
		check("enable kept", q, {24'h0, 1'b1, code[2:0], 4'h9});
		// Code back to 000 right after wake so timers count normally
		wb(1'b1, ADR, 8'h01, q);
	endtask

	task t_hw(input logic standby_enable);
		logic [31:0] q;
		wb(1'b1, ADR, {standby_enable, 7'h01}, q);
		do_sleep(1'b0);
		pdm_pin_model_i.rst(1'b0);
		pdm_pin_model_i.standby_pin(1'b0);
		step();
		check1("hw standby", hwStandby, 1'b1);
		check1("osc off", oscRun, 1'b0);
		pdm_pin_model_i.standby_pin(1'b1);
		step();
		check1("hw standby left", hwStandby, 1'b0);
		check1("osc restarts", oscRun, 1'b1);
		wb(1'b0, ADR, 8'h00, q);
		check("reloaded", q, 32'h09);
		pdm_pin_model_i.rst(1'b1);
		step();
		check1("reset sequence", resetStart, 1'b1);
	endtask

	////////////////////////////////////////
	initial begin
		err_count = 0;
		n_compared = 0;
		reset = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 16'h0000;
		wb_sel_i = 4'hF;
		wbSel = 4'hF;
		wb_dat_i = 32'h0;
		sleepExec = 1'b0;
		cpuMaskI = 1'b0;
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		t_regs();
		t_reset();
		t_sleep(1'b0);
		t_sleep(1'b1);
		t_rst(1'b0);
		t_rst(1'b1);
		for (int c = 0; c < 8; c++) begin
			// Bench clock stands for an external source, so any code is fair
			t_swstby(c);
		end
		t_hw(1'b0);
		t_hw(1'b1);
		summarize();
	end

	// Whole run needs under two thousand cycles
	initial begin
		repeat (40000) @(posedge clk_sys);
		err_count++;
		summarize();
	end
endmodule
